/* hw/sar_adc_pkg.sv */
// Constants, register layout and state codes for the SAR converter control.
// Assumes an 8-bit register port with read data one cycle after the strobe.
package sar_adc_pkg;

    // Register indices on the plain register port
    localparam logic [2:0] ADDR_CONTROL0 = 3'h0;
    localparam logic [2:0] ADDR_CONTROL1 = 3'h1;
    localparam logic [2:0] ADDR_RESULT_HIGH = 3'h2;
    localparam logic [2:0] ADDR_RESULT_LOW = 3'h3;
    localparam logic [2:0] ADDR_FLAG = 3'h4;
    localparam logic [2:0] ADDR_IRQ_ENABLE = 3'h5;

    // Field positions
    localparam int CTRL1_FORMAT_BIT = 7;
    localparam int CTRL1_CLKSEL_HI_BIT = 0;
    localparam int FLAG_DONE_BIT = 0;
    localparam int IRQ_ENABLE_BIT = 0;

    // Reset values
    localparam logic [7:0] CONTROL0_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;

    // Clock source codes (low two select bits)
    localparam logic [1:0] CLKSEL_DIV2 = 2'h0;
    localparam logic [1:0] CLKSEL_DIV8 = 2'h1;
    localparam logic [1:0] CLKSEL_DIV32 = 2'h2;
    localparam logic [1:0] CLKSEL_OSC = 2'h3;

    // Divider terminal counts (divide ratio minus one)
    localparam logic [4:0] DIV2_LAST = 5'h01;
    localparam logic [4:0] DIV8_LAST = 5'h07;
    localparam logic [4:0] DIV32_LAST = 5'h1f;

    // Conversion timing in bit periods, and the first trial code
    localparam logic [3:0] CONV_LAST_TAD = 4'ha;
    localparam logic [1:0] ABORT_WAIT_TADS = 2'h2;
    localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;

    // Channel codes for the two internal references
    localparam logic [3:0] CHAN_CVREF = 4'he;
    localparam logic [3:0] CHAN_FIXED_REF = 4'hf;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_ABORT = 3'b100
    } conv_state_t;

    typedef struct packed {
        logic [1:0] conv_clock_select;
        logic [3:0] channel_select;
        logic go_busy;
        logic converter_enable;
    } control0_t;

endpackage : sar_adc_pkg

/* hw/pin_sync3.sv */
// Three-stage synchroniser for a pin input with agreement filter.
// Assumes the input may change at any time relative to core_clk.
`timescale 1ns/1ps
module pin_sync3 (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Pin side
    input wire logic pin_in,
    // Filtered level
    output logic level_out
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_next;

    // Only a level seen by both later stages is taken, the first stage feeds s2 alone
    assign level_next = (s2_reg == s3_reg) ? s3_reg : level_out;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level_out <= 1'b0;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_out <= level_next;
        end
    end
endmodule : pin_sync3

/* hw/tad_gen.sv */
// Bit-period enable generator: divided core clock or internal oscillator edges.
// Assumes osc_edge is a one-cycle pulse already synchronised to core_clk.
`timescale 1ns/1ps
module tad_gen (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Control
    input wire logic run,
    input wire logic [1:0] clk_sel,
    input wire logic osc_edge,
    // Bit period enable
    output logic tick
);
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    logic [4:0] last_count;
    logic div_hit;
    logic use_osc;

    // Upper select bit never reaches this block; the two low bits alone pick the source
    assign use_osc = (clk_sel == sar_adc_pkg::CLKSEL_OSC);
    assign last_count = (clk_sel == sar_adc_pkg::CLKSEL_DIV2) ? sar_adc_pkg::DIV2_LAST :
                        (clk_sel == sar_adc_pkg::CLKSEL_DIV8) ? sar_adc_pkg::DIV8_LAST :
                        sar_adc_pkg::DIV32_LAST;
    assign div_hit = (cnt_reg == last_count);
    // Divided periods follow the core clock rate; only the oscillator is independent
    assign tick = run && (use_osc ? osc_edge : div_hit);
    assign cnt_next = (!run || div_hit) ? 5'h00 : cnt_reg + 5'h01;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= 5'h00;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule : tad_gen

/* hw/sar_adc_ctrl.sv */
// Control logic of a 10-bit successive-approximation converter.
// Assumes the comparator output is settled and synchronous to core_clk when a
// bit period ends, and that the register master never issues both strobes at once.
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
module sar_adc_ctrl (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Analog front end
    input wire logic osc_pin,
    input wire logic cmp_in,
    output logic [9:0] dac_code,
    output logic hold_connect,
    output logic analog_power,
    output logic [3:0] channel_select,
    output logic ext_input_sel,
    output logic cvref_sel,
    output logic fixed_ref_sel,
    // System
    input wire logic sleep_mode,
    output logic irq_request,
    output logic wake_request
);
    sar_adc_pkg::conv_state_t state_reg;
    sar_adc_pkg::conv_state_t state_next;
    sar_adc_pkg::control0_t ctrl0_reg;
    sar_adc_pkg::control0_t ctrl0_wr_view;
    logic format_reg;
    logic clksel_hi_reg;
    logic done_flag_reg;
    logic done_flag_next;
    logic irq_enable_reg;
    logic [7:0] result_high_reg;
    logic [7:0] result_low_reg;
    logic [7:0] result_high_next;
    logic [7:0] result_low_next;
    logic [9:0] sar_reg;
    logic [9:0] sar_next;
    logic [9:0] bit_mask_reg;
    logic [3:0] tad_cnt_reg;
    logic [1:0] wait_cnt_reg;
    logic [7:0] rdata_next;
    logic osc_level;
    logic osc_level_d_reg;
    logic osc_edge;
    logic tick;
    logic run;
    logic wr_ctrl0;
    logic wr_ctrl1;
    logic wr_flag;
    logic wr_irq_en;
    logic start_req;
    logic abort_req;
    logic done_pulse;
    logic converting;
    logic [7:0] ctrl0_read;
    logic [7:0] ctrl1_read;
    logic [2:0] clk_sel_full;

    // Oscillator pin into core timing, so ticks and completion stay in one domain
    pin_sync3 u_osc_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pin_in(osc_pin),
        .level_out(osc_level)
    );

    assign osc_edge = osc_level && !osc_level_d_reg;
    assign converting = (state_reg == sar_adc_pkg::ST_CONV);
    assign run = (state_reg != sar_adc_pkg::ST_IDLE);
    assign clk_sel_full = {clksel_hi_reg, ctrl0_reg.conv_clock_select};

    tad_gen u_tad_gen (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .run(run),
        .clk_sel(ctrl0_reg.conv_clock_select),
        .osc_edge(osc_edge),
        .tick(tick)
    );

    // Register decode
    assign wr_ctrl0 = reg_wr && (reg_addr == sar_adc_pkg::ADDR_CONTROL0);
    assign wr_ctrl1 = reg_wr && (reg_addr == sar_adc_pkg::ADDR_CONTROL1);
    assign wr_flag = reg_wr && (reg_addr == sar_adc_pkg::ADDR_FLAG);
    assign wr_irq_en = reg_wr && (reg_addr == sar_adc_pkg::ADDR_IRQ_ENABLE);
    assign ctrl0_wr_view = reg_wdata;

    // A start needs the converter already on, so a combined enable-and-go write enables but does not start
    assign start_req = wr_ctrl0 && ctrl0_wr_view.go_busy && ctrl0_reg.converter_enable
                       && ctrl0_wr_view.converter_enable
                       && (state_reg == sar_adc_pkg::ST_IDLE);
    assign abort_req = wr_ctrl0 && !ctrl0_wr_view.go_busy && converting;
    assign done_pulse = converting && tick && (tad_cnt_reg == sar_adc_pkg::CONV_LAST_TAD)
                        && !abort_req && !(wr_ctrl0 && !ctrl0_wr_view.converter_enable);

    // Conversion sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            sar_adc_pkg::ST_IDLE: begin
                if (start_req) begin
                    state_next = sar_adc_pkg::ST_CONV;
                end
            end
            sar_adc_pkg::ST_CONV: begin
                if (abort_req) begin
                    state_next = sar_adc_pkg::ST_ABORT;
                end else if (done_pulse) begin
                    state_next = sar_adc_pkg::ST_IDLE;
                end
            end
            sar_adc_pkg::ST_ABORT: begin
                if (tick && (wait_cnt_reg == sar_adc_pkg::ABORT_WAIT_TADS - 2'h1)) begin
                    state_next = sar_adc_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = sar_adc_pkg::ST_IDLE;
            end
        endcase
        // Turning the converter off drops everything in flight
        if (wr_ctrl0 && !ctrl0_wr_view.converter_enable) begin
            state_next = sar_adc_pkg::ST_IDLE;
        end
    end

    // Successive approximation: first period opens the trial, then MSB to LSB
    always_comb begin
        sar_next = sar_reg;
        if (converting && tick) begin
            if (tad_cnt_reg == 4'h0) begin
                sar_next = sar_adc_pkg::SAR_FIRST_TRIAL;
            end else begin
                sar_next = cmp_in ? sar_reg : (sar_reg & ~bit_mask_reg);
                sar_next = sar_next | (bit_mask_reg >> 1);
            end
        end
    end

    // Justification applied at load time, the pair then reads as stored
    always_comb begin
        result_high_next = result_high_reg;
        result_low_next = result_low_reg;
        if (done_pulse) begin
            if (format_reg) begin
                result_high_next = {6'h00, sar_next[9:8]};
                result_low_next = sar_next[7:0];
            end else begin
                result_high_next = sar_next[9:2];
                result_low_next = {sar_next[1:0], 6'h00};
            end
        end
    end

    // Hardware set wins over a software clear in the same cycle
    assign done_flag_next = done_pulse ? 1'b1 :
                            (wr_flag ? reg_wdata[sar_adc_pkg::FLAG_DONE_BIT] : done_flag_reg);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= sar_adc_pkg::ST_IDLE;
            sar_reg <= 10'h000;
            bit_mask_reg <= 10'h000;
            tad_cnt_reg <= 4'h0;
            wait_cnt_reg <= 2'h0;
            osc_level_d_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sar_reg <= sar_next;
            osc_level_d_reg <= osc_level;
            if (start_req) begin
                tad_cnt_reg <= 4'h0;
                bit_mask_reg <= sar_adc_pkg::SAR_FIRST_TRIAL;
            end else if (converting && tick) begin
                tad_cnt_reg <= tad_cnt_reg + 4'h1;
                if (tad_cnt_reg != 4'h0) begin
                    bit_mask_reg <= bit_mask_reg >> 1;
                end
            end
            if (abort_req) begin
                wait_cnt_reg <= 2'h0;
            end else if (tick && (state_reg == sar_adc_pkg::ST_ABORT)) begin
                wait_cnt_reg <= wait_cnt_reg + 2'h1;
            end
        end
    end

    // Software registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl0_reg <= sar_adc_pkg::CONTROL0_RESET;
            format_reg <= 1'b0;
            clksel_hi_reg <= 1'b0;
            done_flag_reg <= 1'b0;
            irq_enable_reg <= 1'b0;
            result_high_reg <= sar_adc_pkg::RESULT_RESET;
            result_low_reg <= sar_adc_pkg::RESULT_RESET;
            reg_rdata <= 8'h00;
        end else begin
            if (wr_ctrl0) begin
                ctrl0_reg <= ctrl0_wr_view;
            end
            if (wr_ctrl1) begin
                format_reg <= reg_wdata[sar_adc_pkg::CTRL1_FORMAT_BIT];
                clksel_hi_reg <= reg_wdata[sar_adc_pkg::CTRL1_CLKSEL_HI_BIT];
            end
            if (wr_irq_en) begin
                irq_enable_reg <= reg_wdata[sar_adc_pkg::IRQ_ENABLE_BIT];
            end
            done_flag_reg <= done_flag_next;
            result_high_reg <= result_high_next;
            result_low_reg <= result_low_next;
            reg_rdata <= rdata_next;
        end
    end

    // Go reads the live sequencer state, so completion and abort clear it at once
    assign ctrl0_read = {ctrl0_reg.conv_clock_select, ctrl0_reg.channel_select,
                         converting, ctrl0_reg.converter_enable};
    assign ctrl1_read = {format_reg, 6'h00, clksel_hi_reg};
    assign rdata_next = !reg_rd ? 8'h00 :
                        (reg_addr == sar_adc_pkg::ADDR_CONTROL0) ? ctrl0_read :
                        (reg_addr == sar_adc_pkg::ADDR_CONTROL1) ? ctrl1_read :
                        (reg_addr == sar_adc_pkg::ADDR_RESULT_HIGH) ? result_high_reg :
                        (reg_addr == sar_adc_pkg::ADDR_RESULT_LOW) ? result_low_reg :
                        (reg_addr == sar_adc_pkg::ADDR_FLAG) ? {7'h00, done_flag_reg} :
                        (reg_addr == sar_adc_pkg::ADDR_IRQ_ENABLE) ? {7'h00, irq_enable_reg} :
                        8'h00;

    // Analog side
    assign dac_code = sar_reg;
    // Stays open through the abort wait; acquisition resumes only back in idle
    assign hold_connect = (state_reg == sar_adc_pkg::ST_IDLE);
    assign analog_power = ctrl0_reg.converter_enable;
    assign channel_select = ctrl0_reg.channel_select;
    assign ext_input_sel = (ctrl0_reg.channel_select < sar_adc_pkg::CHAN_CVREF);
    assign cvref_sel = (ctrl0_reg.channel_select == sar_adc_pkg::CHAN_CVREF);
    assign fixed_ref_sel = (ctrl0_reg.channel_select == sar_adc_pkg::CHAN_FIXED_REF);
    assign irq_request = done_flag_reg && irq_enable_reg;
    assign wake_request = irq_request && sleep_mode;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_abort_enter;
        converting && abort_req && ctrl0_wr_view.converter_enable;
    endsequence

    sequence s_two_tads;
        (state_reg == sar_adc_pkg::ST_ABORT) ##0 (tick && wait_cnt_reg == 2'h1);
    endsequence

    chk_osc_source: assert property (
        (converting && tick && clk_sel_full[1:0] == sar_adc_pkg::CLKSEL_OSC) |-> osc_edge)
        else $error("oscillator selected but tick without oscillator edge");

    chk_div2_period: assert property (
        (converting && tick && ctrl0_reg.conv_clock_select == sar_adc_pkg::CLKSEL_DIV2
         && !reg_wr) |=> !tick ##1 (tick || !converting || $past(reg_wr)))
        else $error("divide-by-two bit period not two cycles");

    chk_eleven_tads: assert property (
        done_pulse |-> (tad_cnt_reg == 4'ha) && $past(converting))
        else $error("completion not at eleventh bit period");

    chk_done_effects: assert property (
        done_pulse |=> done_flag_reg && !ctrl0_read[1] && (state_reg == sar_adc_pkg::ST_IDLE))
        else $error("completion did not clear go and set flag");

    chk_flag_sticky: assert property (
        (done_flag_reg && !wr_flag) |=> done_flag_reg)
        else $error("done flag cleared without a write");

    chk_irq_follows: assert property (
        (done_pulse && irq_enable_reg && !wr_irq_en) |=> irq_request)
        else $error("interrupt not requested after completion");

    chk_abort_keeps: assert property (
        s_abort_enter |=> $stable(result_high_reg) && $stable(result_low_reg))
        else $error("result changed on abort");

    chk_abort_wait: assert property (
        s_abort_enter |=> !hold_connect && (state_reg == sar_adc_pkg::ST_ABORT))
        else $error("abort wait left early");

    chk_abort_exit: assert property (
        s_two_tads |=> hold_connect && (state_reg == sar_adc_pkg::ST_IDLE))
        else $error("acquisition not resumed after two bit periods");

    chk_disable_idle: assert property (
        (wr_ctrl0 && !ctrl0_wr_view.converter_enable) |=> (state_reg == sar_adc_pkg::ST_IDLE)
        && !analog_power)
        else $error("converter still active when disabled");

    chk_go_busy: assert property (
        (reg_rd && reg_addr == sar_adc_pkg::ADDR_CONTROL0) |=> reg_rdata[1] == $past(converting))
        else $error("go bit does not show conversion state");

endmodule : sar_adc_ctrl

/* tb/sar_adc_ctrl_test.sv */
// Self-checking bench for the SAR converter control block.
// Assumes the register map of the package and a comparator modelled from a fixed input level.
`timescale 1ns/1ps
module sar_adc_ctrl_test;
    typedef struct {logic [1:0] sel; logic up; logic fmt; logic irq; logic [3:0] chan;
        logic [9:0] vin;} conv_row_t;
    logic core_clk, rst_b, reg_wr, reg_rd, osc_pin, cmp_in, sleep_mode;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic [9:0] dac_code, vin;
    logic [3:0] channel_select;
    logic hold_connect, analog_power, ext_input_sel, cvref_sel, fixed_ref_sel;
    logic irq_request, wake_request;
    logic [2:0] osc_cnt;
    int fails, n_compared, n;
    conv_row_t rows[5] = '{
        '{2'h0, 1'b0, 1'b1, 1'b0, 4'he, 10'h3ff},
        '{2'h1, 1'b0, 1'b0, 1'b0, 4'hf, 10'h155},
        '{2'h2, 1'b1, 1'b1, 1'b0, 4'h3, 10'h2aa},
        '{2'h3, 1'b0, 1'b0, 1'b0, 4'h0, 10'h001},
        '{2'h3, 1'b1, 1'b1, 1'b1, 4'hd, 10'h201}};

    sar_adc_ctrl u_sar_adc_ctrl (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .osc_pin(osc_pin), .cmp_in(cmp_in), .dac_code(dac_code), .hold_connect(hold_connect),
        .analog_power(analog_power), .channel_select(channel_select),
        .ext_input_sel(ext_input_sel), .cvref_sel(cvref_sel), .fixed_ref_sel(fixed_ref_sel),
        .sleep_mode(sleep_mode), .irq_request(irq_request), .wake_request(wake_request));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Comparator answers from the last trial value; oscillator pin runs at one eighth of core
    always @(posedge core_clk) begin
        cmp_in <= (vin >= dac_code);
        osc_cnt <= osc_cnt + 3'h1;
        osc_pin <= osc_cnt[2];
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    // Counts edges until the hold capacitor reconnects; bounded so a stuck design cannot hang
    task automatic measure(output int cnt);
        cnt = 0;
        do begin
            @(posedge core_clk);
            #1 cnt++;
        end while (hold_connect === 1'b0 && cnt < 5000);
    endtask : measure

    task automatic conclude();
        if (fails == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        conclude();
    end

    initial begin
        rst_b = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        sleep_mode = 1'b0;
        vin = 10'h000;
        cmp_in = 1'b0;
        osc_pin = 1'b0;
        osc_cnt = 3'h0;
        fails = 0;
        n_compared = 0;
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        #1;
        chk("hold_connect at reset", hold_connect, 1'b1);
        chk("analog_power at reset", analog_power, 1'b0);
        chk("ext_input_sel at reset", ext_input_sel, 1'b1);
        // Includes the two unmapped addresses, which must read zero
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), d);
            chk("register after reset", d, 8'h00);
        end

        foreach (rows[i]) begin
            vin = rows[i].vin;
            // Oscillator rows convert asleep, the only use advised at this core rate
            @(posedge core_clk);
            sleep_mode <= (rows[i].sel == 2'h3);
            wr(sar_adc_pkg::ADDR_CONTROL1, {rows[i].fmt, 6'h00, rows[i].up});
            wr(sar_adc_pkg::ADDR_IRQ_ENABLE, {7'h00, rows[i].irq});
            wr(sar_adc_pkg::ADDR_FLAG, 8'h00);
            wr(sar_adc_pkg::ADDR_CONTROL0, {rows[i].sel, rows[i].chan, 2'b01});
            #1;
            chk("analog_power", analog_power, 1'b1);
            chk("channel_select", channel_select, rows[i].chan);
            chk("ext_input_sel", ext_input_sel, rows[i].chan < 4'he);
            chk("cvref_sel", cvref_sel, rows[i].chan == 4'he);
            chk("fixed_ref_sel", fixed_ref_sel, rows[i].chan == 4'hf);
            chk("hold_connect idle", hold_connect, 1'b1);
            wr(sar_adc_pkg::ADDR_CONTROL0, {rows[i].sel, rows[i].chan, 2'b11});
            measure(n);
            // n counts the edges from the start edge to the completion edge
            if (rows[i].sel == 2'h3)
                chk("oscillator conversion span", (n >= 80) && (n <= 100), 1'b1);
            else
                chk("cycles", 16'(n), 16'(11 * (2 << (2 * rows[i].sel))));
            chk("dac_code final", dac_code, rows[i].vin);
            rd(sar_adc_pkg::ADDR_CONTROL0, d);
            chk("go after completion", d[1], 1'b0);
            rd(sar_adc_pkg::ADDR_FLAG, d);
            chk("done flag", d, 8'h01);
            chk("irq_request", irq_request, rows[i].irq);
            chk("wake_request row", wake_request, rows[i].irq && rows[i].sel == 2'h3);
            rd(sar_adc_pkg::ADDR_RESULT_HIGH, d);
            chk("result_high", d, rows[i].fmt ? {6'h00, rows[i].vin[9:8]} : rows[i].vin[9:2]);
            rd(sar_adc_pkg::ADDR_RESULT_LOW, d);
            chk("result_low", d, rows[i].fmt ? rows[i].vin[7:0] : {rows[i].vin[1:0], 6'h00});
        end

        // Flag stays set with no software action; wake only while asleep
        repeat (50) @(posedge core_clk);
        rd(sar_adc_pkg::ADDR_FLAG, d);
        chk("flag held", d, 8'h01);
        @(posedge core_clk);
        sleep_mode <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1 chk("wake_request", wake_request, 1'b1);
        wr(sar_adc_pkg::ADDR_IRQ_ENABLE, 8'h00);
        #1 chk("irq masked", irq_request, 1'b0);
        rd(sar_adc_pkg::ADDR_FLAG, d);
        chk("flag with irq masked", d, 8'h01);
        wr(sar_adc_pkg::ADDR_IRQ_ENABLE, 8'h01);
        wr(sar_adc_pkg::ADDR_FLAG, 8'h00);
        repeat (2) @(posedge core_clk);
        #1 chk("irq after clear", irq_request, 1'b0);
        chk("wake after clear", wake_request, 1'b0);
        sleep_mode <= 1'b0;

        // Abort in mid-conversion with a different input so a wrong load would show
        vin = 10'h0f0;
        wr(sar_adc_pkg::ADDR_CONTROL0, 8'h41);
        wr(sar_adc_pkg::ADDR_CONTROL0, 8'h43);
        repeat (20) @(posedge core_clk);
        rd(sar_adc_pkg::ADDR_CONTROL0, d);
        chk("go while converting", d[1], 1'b1);
        wr(sar_adc_pkg::ADDR_CONTROL0, 8'h41);
        measure(n);
        chk("abort wait span", (n - 1 >= 8) && (n - 1 <= 18), 1'b1);
        rd(sar_adc_pkg::ADDR_RESULT_HIGH, d);
        chk("result_high kept", d, 8'h02);
        rd(sar_adc_pkg::ADDR_RESULT_LOW, d);
        chk("result_low kept", d, 8'h01);
        rd(sar_adc_pkg::ADDR_FLAG, d);
        chk("flag after abort", d, 8'h00);

        // Enable and go in one write from off must not start
        wr(sar_adc_pkg::ADDR_CONTROL0, 8'h00);
        wr(sar_adc_pkg::ADDR_CONTROL0, 8'h03);
        repeat (4) @(posedge core_clk);
        #1 chk("no start in enabling write", hold_connect, 1'b1);
        rd(sar_adc_pkg::ADDR_CONTROL0, d);
        chk("go refused", d[1], 1'b0);

        // Reset in mid-conversion stops everything
        wr(sar_adc_pkg::ADDR_CONTROL0, 8'h81);
        wr(sar_adc_pkg::ADDR_CONTROL0, 8'h83);
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 chk("hold_connect in reset", hold_connect, 1'b1);
        chk("analog_power in reset", analog_power, 1'b0);
        @(posedge core_clk);
        rst_b <= 1'b1;
        rd(sar_adc_pkg::ADDR_CONTROL0, d);
        chk("control0 after reset", d, 8'h00);
        rd(sar_adc_pkg::ADDR_RESULT_LOW, d);
        chk("result_low after reset", d, 8'h00);
        conclude();
    end
endmodule : sar_adc_ctrl_test
